// [hw/lbf_regs.svh]
`ifndef LBF_REGS_SVH
`define LBF_REGS_SVH

`define LBF_CLK_NS      4
`define LBF_BIT_NS      833333
`define LBF_STOP_NS     2450000
`define LBF_BREAK_NS    1200000
`define LBF_RECOV_NS    4000000
`define LBF_SET_HI_NS   13500000
`define LBF_SET_MH_NS   14900000
`define LBF_SET_MI_NS   16300000
`define LBF_SET_ML_NS   17900000
`define LBF_SET_LO_NS   19500000
`define LBF_CEIL(ns)    (((ns) + `LBF_CLK_NS - 1) / `LBF_CLK_NS)
`define LBF_HALF_CYC    ((`LBF_BIT_NS + 2 * `LBF_CLK_NS - 1) / (2 * `LBF_CLK_NS))
`define LBF_SYNC_LAT    24'h000004
`define LBF_PRIO_HI     3'h1
`define LBF_PRIO_MH     3'h2
`define LBF_PRIO_MI     3'h3
`define LBF_PRIO_ML     3'h4
`define LBF_PRIO_LO     3'h5
`define LBF_LEN_8       2'h0
`define LBF_LEN_16      2'h1
`define LBF_LEN_24      2'h2
`define LBF_FIFO_DEPTH  8

`endif

// [hw/lbf_pkg.sv]
`default_nettype none
package lbf_pkg;
    typedef enum logic [5:0] {
        TX_IDLE   = 6'h01,
        TX_SETTLE = 6'h02,
        TX_SEND   = 6'h04,
        TX_STOP   = 6'h08,
        TX_BREAK  = 6'h10,
        TX_RECOV  = 6'h20
    } lbf_tx_t;

    typedef struct packed {
        logic [23:0] data;
        logic [1:0]  len;
        logic [2:0]  prio;
        logic        twice;
    } lbf_req_t;

    typedef struct packed {
        logic        s1;
        logic        s2;
        logic        s3;
        lbf_tx_t     tst;
        logic [23:0] cnt;
        logic        half;
        logic [4:0]  bidx;
        logic [4:0]  nbits;
        logic [24:0] frame;
        logic [24:0] shreg;
        logic [2:0]  prio;
        logic        twice;
        logic        second;
        logic        oe;
        logic        coll;
        logic        busy;
        logic        rbusy;
        logic        rph;
        logic        rb0;
        logic        rstart;
        logic [23:0] rcnt;
        logic [4:0]  rnb;
        logic [23:0] rsh;
        logic [23:0] rdata;
        logic [1:0]  rlen;
        logic        rvalid;
        logic        ferr;
    } lbf_st_t;
endpackage : lbf_pkg
`default_nettype wire

// [hw/lbf_link.sv]
// Notes on behaviour
// - A frame is one start bit, the data bits, then one stop condition.
// - Data bits go out and come in most significant bit first.
// - Bits are Manchester coded at 1200 bit/s, 0.833 ms per bit.
// - The idle stop level is held at least 2.45 ms after the last bit.
// - Each command frame waits a priority settling time on an idle line.
// - Send-twice commands go out twice within 100 ms, nothing between.
// - The second copy of a send-twice command uses the High settling time.
// - High settling time is used for that second copy and nothing else.
// - A frame carries 9, 17 or 25 bits counting the start bit.
// - Low is driven actively, high means the output is released.
// - Bus access starts only while the line is seen idle high.
// - Seeing low while releasing is a collision and starts a low break.
// - After a break on a still-low line, wait idle then resend with settling.
// - After a break on an idle line, recover then resend without settling.
// - The break lasts 1.2 to 1.4 ms.
// - The recover sequence lasts 4.0 to 4.6 ms.
`include "lbf_regs.svh"
`default_nettype none

module lbf_fifo #(
    parameter int WIDTH = 30,
    parameter int DEPTH = `LBF_FIFO_DEPTH
) (
    input  wire logic             mclk_i,
    input  wire logic             rstn_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic [WIDTH-1:0]      out_data_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
        logic                        nfull;
        logic                        nempty;
    } lbf_fst_t;

    lbf_fst_t st;
    lbf_fst_t next_st;
    logic     push;
    logic     pop;

    always_comb begin
        next_st = st;
        push = in_valid_i & st.nfull;
        pop = out_ready_i & st.nempty;
        if (push) begin
            next_st.mem[st.wp] = in_data_i;
            next_st.wp = AW'((st.wp + 1'b1) % DEPTH);
        end
        if (pop) begin
            next_st.rp = AW'((st.rp + 1'b1) % DEPTH);
        end
        next_st.cnt = st.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        next_st.nfull = next_st.cnt != (AW + 1)'(DEPTH);
        next_st.nempty = next_st.cnt != '0;
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= '0;
            st.nfull <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign in_ready_o  = st.nfull;
    assign out_valid_o = st.nempty;
    assign out_data_o  = st.mem[st.rp];
endmodule : lbf_fifo

module lbf_link
    import lbf_pkg::*;
#(
    parameter logic [23:0] HALF_CYC   = 24'(`LBF_HALF_CYC),
    parameter logic [23:0] STOP_CYC   = 24'(`LBF_CEIL(`LBF_STOP_NS)),
    parameter logic [23:0] BREAK_CYC  = 24'(`LBF_CEIL(`LBF_BREAK_NS)),
    parameter logic [23:0] RECOV_CYC  = 24'(`LBF_CEIL(`LBF_RECOV_NS)),
    parameter logic [23:0] SET_HI_CYC = 24'(`LBF_CEIL(`LBF_SET_HI_NS)),
    parameter logic [23:0] SET_MH_CYC = 24'(`LBF_CEIL(`LBF_SET_MH_NS)),
    parameter logic [23:0] SET_MI_CYC = 24'(`LBF_CEIL(`LBF_SET_MI_NS)),
    parameter logic [23:0] SET_ML_CYC = 24'(`LBF_CEIL(`LBF_SET_ML_NS)),
    parameter logic [23:0] SET_LO_CYC = 24'(`LBF_CEIL(`LBF_SET_LO_NS)),
    parameter int          DEPTH      = `LBF_FIFO_DEPTH
) (
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    input  wire logic        tx_valid_i,
    input  wire logic [23:0] tx_data_i,
    input  wire logic [1:0]  tx_len_i,
    input  wire logic [2:0]  tx_prio_i,
    input  wire logic        tx_twice_i,
    output logic             tx_ready_o,
    input  wire logic        line_i,
    output logic             line_o,
    output logic             line_oe_o,
    output logic             rx_valid_o,
    output logic [23:0]      rx_data_o,
    output logic [1:0]       rx_len_o,
    output logic             rx_ferr_o,
    output logic             coll_o,
    output logic             busy_o
);
    lbf_st_t     st;
    lbf_st_t     next_st;
    lbf_req_t    req_in;
    lbf_req_t    req;
    logic        q_valid;
    logic        pop;
    logic        txa;
    logic [23:0] settle_cyc;

    assign req_in = '{data: tx_data_i, len: tx_len_i, prio: tx_prio_i, twice: tx_twice_i};

    // The queue lets software post several commands while one is still waiting out its
    // settling time; its ready is the only back-pressure toward the source.
    lbf_fifo #(
        .WIDTH ($bits(lbf_req_t)),
        .DEPTH (DEPTH)
    ) u_fifo (
        .mclk_i      (mclk_i),
        .rstn_i      (rstn_i),
        .in_valid_i  (tx_valid_i),
        .in_data_i   (req_in),
        .in_ready_o  (tx_ready_o),
        .out_valid_o (q_valid),
        .out_data_o  (req),
        .out_ready_i (pop)
    );

    always_comb begin
        case (st.prio)
            `LBF_PRIO_HI: settle_cyc = SET_HI_CYC;
            `LBF_PRIO_MH: settle_cyc = SET_MH_CYC;
            `LBF_PRIO_MI: settle_cyc = SET_MI_CYC;
            `LBF_PRIO_ML: settle_cyc = SET_ML_CYC;
            default:      settle_cyc = SET_LO_CYC;
        endcase
    end

    always_comb begin
        next_st = st;
        next_st.s1 = line_i;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.coll = 1'b0;
        next_st.rvalid = 1'b0;
        next_st.ferr = 1'b0;
        next_st.cnt = st.cnt + 24'h000001;
        pop = 1'b0;
        case (st.tst)
            TX_IDLE: begin
                next_st.cnt = '0;
                if (q_valid) begin
                    pop = 1'b1;
                    next_st.tst = TX_SETTLE;
                    next_st.twice = req.twice;
                    next_st.second = 1'b0;
                    // A request for High is demoted; that slot belongs to second copies.
                    next_st.prio = (req.prio == `LBF_PRIO_HI || req.prio == 3'h0)
                                 ? `LBF_PRIO_MH : req.prio;
                    case (req.len)
                        `LBF_LEN_8: begin
                            next_st.frame = {1'b1, req.data[7:0], 16'h0000};
                            next_st.nbits = 5'h09;
                        end
                        `LBF_LEN_16: begin
                            next_st.frame = {1'b1, req.data[15:0], 8'h00};
                            next_st.nbits = 5'h11;
                        end
                        default: begin
                            next_st.frame = {1'b1, req.data};
                            next_st.nbits = 5'h19;
                        end
                    endcase
                end
            end
            TX_SETTLE: begin
                if (!st.s2) begin
                    next_st.cnt = '0;
                end else if (st.cnt >= settle_cyc - 24'h000001) begin
                    next_st.tst = TX_SEND;
                    next_st.shreg = st.frame;
                    next_st.half = 1'b0;
                    next_st.bidx = '0;
                    next_st.cnt = '0;
                end
            end
            TX_SEND: begin
                if (!st.oe && st.cnt == HALF_CYC / 2 && !st.s2) begin
                    next_st.tst = TX_BREAK;
                    next_st.coll = 1'b1;
                    next_st.cnt = '0;
                end else if (st.cnt == HALF_CYC - 24'h000001) begin
                    next_st.cnt = '0;
                    next_st.half = ~st.half;
                    if (st.half) begin
                        next_st.shreg = {st.shreg[23:0], 1'b0};
                        next_st.bidx = st.bidx + 5'h01;
                        if (st.bidx == st.nbits - 5'h01) begin
                            next_st.tst = TX_STOP;
                        end
                    end
                end
            end
            TX_STOP: begin
                if (st.cnt == STOP_CYC - 24'h000001) begin
                    next_st.cnt = '0;
                    if (st.twice && !st.second) begin
                        next_st.second = 1'b1;
                        next_st.prio = `LBF_PRIO_HI;
                        next_st.tst = TX_SETTLE;
                    end else begin
                        next_st.tst = TX_IDLE;
                    end
                end
            end
            TX_BREAK: begin
                if (st.cnt == BREAK_CYC - 24'h000001) begin
                    next_st.tst = TX_RECOV;
                    next_st.cnt = '0;
                end
            end
            TX_RECOV: begin
                // The check waits out the synchroniser so our own break is not seen.
                if (st.cnt == `LBF_SYNC_LAT && !st.s2) begin
                    next_st.tst = TX_SETTLE;
                    next_st.cnt = '0;
                end else if (st.cnt == RECOV_CYC - 24'h000001) begin
                    next_st.tst = TX_SEND;
                    next_st.shreg = st.frame;
                    next_st.half = 1'b0;
                    next_st.bidx = '0;
                    next_st.cnt = '0;
                end
            end
            default: begin
                next_st.tst = TX_IDLE;
                next_st.cnt = '0;
            end
        endcase

        // A one bit drives low in the first half and releases in the second.
        if (next_st.tst == TX_SEND) begin
            next_st.oe = next_st.shreg[24] ^ next_st.half;
        end else begin
            next_st.oe = next_st.tst == TX_BREAK;
        end
        next_st.busy = next_st.tst != TX_IDLE;

        // Our own frames are not received; replies arrive while we settle.
        txa = st.tst != TX_IDLE && st.tst != TX_SETTLE;
        if (!st.rbusy) begin
            if (!txa && st.s3 && !st.s2) begin
                next_st.rbusy = 1'b1;
                next_st.rcnt = '0;
                next_st.rph = 1'b0;
                next_st.rnb = '0;
                next_st.rstart = 1'b0;
                next_st.rsh = '0;
            end
        end else begin
            next_st.rcnt = st.rcnt + 24'h000001;
            if (st.rcnt == HALF_CYC - 24'h000001) begin
                next_st.rcnt = '0;
                next_st.rph = ~st.rph;
            end
            if (st.rcnt == HALF_CYC / 2) begin
                if (!st.rph) begin
                    next_st.rb0 = st.s2;
                end else if (st.rb0 && st.s2) begin
                    next_st.rbusy = 1'b0;
                    if (st.rstart && (st.rnb == 5'h08 || st.rnb == 5'h10 || st.rnb == 5'h18)) begin
                        next_st.rvalid = 1'b1;
                        next_st.rdata = st.rsh;
                        next_st.rlen = (st.rnb == 5'h08) ? `LBF_LEN_8 :
                                       (st.rnb == 5'h10) ? `LBF_LEN_16 : `LBF_LEN_24;
                    end else begin
                        next_st.ferr = 1'b1;
                    end
                end else if (st.rb0 == st.s2 || (!st.rstart && st.rb0)
                             || st.rnb == 5'h18) begin
                    next_st.rbusy = 1'b0;
                    next_st.ferr = 1'b1;
                end else if (!st.rstart) begin
                    next_st.rstart = 1'b1;
                end else begin
                    next_st.rsh = {st.rsh[22:0], st.s2};
                    next_st.rnb = st.rnb + 5'h01;
                end
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= '0;
            st.s1 <= 1'b1;
            st.s2 <= 1'b1;
            st.s3 <= 1'b1;
            st.tst <= TX_IDLE;
            st.prio <= `LBF_PRIO_LO;
        end else begin
            st <= next_st;
        end
    end

    assign line_o     = 1'b0;
    assign line_oe_o  = st.oe;
    assign rx_valid_o = st.rvalid;
    assign rx_data_o  = st.rdata;
    assign rx_len_o   = st.rlen;
    assign rx_ferr_o  = st.ferr;
    assign coll_o     = st.coll;
    assign busy_o     = st.busy;
endmodule : lbf_link
`default_nettype wire

// [sim/lbf_link_asserts.sv]
`default_nettype none
module lbf_link_asserts #(
    parameter logic [23:0] HALF_CYC  = 24'h000028,
    parameter logic [23:0] STOP_CYC  = 24'h000064,
    parameter logic [23:0] BREAK_CYC = 24'h000032
) (
    input wire logic        mclk_i,
    input wire logic        rstn_i,
    input wire logic        line_i,
    input wire logic        line_o,
    input wire logic        line_oe_o,
    input wire logic        rx_valid_o,
    input wire logic [23:0] rx_data_o,
    input wire logic [1:0]  rx_len_o,
    input wire logic        rx_ferr_o,
    input wire logic        coll_o,
    input wire logic        busy_o
);
    logic [23:0] hi_run;
    logic [23:0] lo_run;
    // Run lengths of the enable expose half-bit, break and stop widths in one place.
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hi_run <= 24'h000000;
            lo_run <= 24'h000000;
        end else begin
            hi_run <= line_oe_o ? hi_run + 24'h000001 : 24'h000000;
            lo_run <= line_oe_o ? 24'h000000 : lo_run + 24'h000001;
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    a_drive_low: assert property (line_o == 1'b0)
        else $error("line drive value is not low");
    a_high_width: assert property ($fell(line_oe_o) |-> hi_run == HALF_CYC
        || hi_run == 2 * HALF_CYC || hi_run == BREAK_CYC)
        else $error("low drive run has an illegal width");
    a_stop_hold: assert property ($fell(busy_o) |-> lo_run + 24'h000001 >= STOP_CYC)
        else $error("stop condition too short");
    a_break_low: assert property (coll_o |-> ##1 line_oe_o [*8])
        else $error("break does not hold the line low");
    a_coll_cause: assert property (coll_o |-> !$past(line_oe_o)
        && !($past(line_i, 2) && $past(line_i, 3) && $past(line_i, 4)))
        else $error("collision flagged without cause");
    a_settle_quiet: assert property ($rose(busy_o) |-> !line_oe_o [*8])
        else $error("frame started without settling");
    a_access_idle: assert property ($rose(line_oe_o) && lo_run > 2 * HALF_CYC
        |-> $past(line_i, 3) && $past(line_i, 4))
        else $error("bus access on a busy line");
    a_rx_single: assert property (rx_valid_o |-> !rx_ferr_o ##1 !rx_valid_o)
        else $error("receive pulse malformed");
    a_rx_len: assert property (rx_valid_o |-> rx_len_o != 2'h3)
        else $error("received length code illegal");
    a_rx_hold: assert property ($changed(rx_data_o) |-> rx_valid_o)
        else $error("receive data changed without a valid frame");
    c_coll: cover property (coll_o);
    c_rx: cover property (rx_valid_o);
    c_ferr: cover property (rx_ferr_o);
endmodule : lbf_link_asserts

bind lbf_link lbf_link_asserts #(
    .HALF_CYC(HALF_CYC), .STOP_CYC(STOP_CYC), .BREAK_CYC(BREAK_CYC)
) u_chk (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .line_i(line_i), .line_o(line_o),
    .line_oe_o(line_oe_o), .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o),
    .rx_len_o(rx_len_o), .rx_ferr_o(rx_ferr_o), .coll_o(coll_o), .busy_o(busy_o)
);
`default_nettype wire

// [sim/lbf_far.sv]
`default_nettype none
module lbf_far #(
    parameter int HC = 40
) (
    input  wire logic mclk_i,
    input  wire logic dut_oe_i,
    output logic      bus_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic oe = 1'b0;
    // Pull-up wire: any enabled driver wins, so released means high.
    assign bus_o = !(dut_oe_i || oe);
    task automatic tick();
        @(posedge mclk_i);
        #1;
    endtask : tick
    // A bad frame turns its last bit into a low-low pair.
    task automatic send(input logic [24:0] v, input int n, input logic bad);
        for (int i = n - 1; i >= 0; i--) begin
            oe = v[i] || (bad && i == 0);
            repeat (HC) tick();
            oe = !v[i] || (bad && i == 0);
            repeat (HC) tick();
        end
        oe = 1'b0;
        repeat (HC * 6) tick();
    endtask : send
    task automatic pull(input int n);
        oe = 1'b1;
        repeat (n) tick();
        oe = 1'b0;
    endtask : pull
endmodule : lbf_far
`default_nettype wire

// [sim/lbf_link_test.sv]
`default_nettype none
module lbf_link_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [23:0] HC = 24'h000028;
    localparam logic [23:0] ST = 24'h000064;
    localparam logic [23:0] RC = 24'h000096;
    localparam logic [23:0] SH = 24'h0000C8;
    localparam int          TL = 32'h0000000C;
    localparam logic [23:0] BK = 24'h000032;
    localparam logic [23:0] SM = 24'h0000DC;
    localparam logic [23:0] SI = 24'h0000F0;
    localparam logic [23:0] SL = 24'h000104;
    localparam logic [23:0] SW = 24'h000118;
    localparam int          DP = 8;
    logic        mclk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        tx_valid_i = 1'b0;
    logic [23:0] tx_data_i = 24'h000000;
    logic [1:0]  tx_len_i = 2'h0;
    logic [2:0]  tx_prio_i = 3'h3;
    logic        tx_twice_i = 1'b0;
    logic        tx_ready_o, line_oe_o, rx_valid_o, rx_ferr_o, coll_o, busy_o;
    logic [23:0] rx_data_o;
    logic [1:0]  rx_len_o;
    wire logic   bus;
    int          bad_count = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          t_take, t_rise, t_end;
    lbf_link #(
        .HALF_CYC(HC), .STOP_CYC(ST), .BREAK_CYC(BK), .RECOV_CYC(RC),
        .SET_HI_CYC(SH), .SET_MH_CYC(SM), .SET_MI_CYC(SI),
        .SET_ML_CYC(SL), .SET_LO_CYC(SW), .DEPTH(DP)
    ) DUT (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i),
        .tx_len_i(tx_len_i), .tx_prio_i(tx_prio_i), .tx_twice_i(tx_twice_i),
        .tx_ready_o(tx_ready_o), .line_i(bus), .line_o(), .line_oe_o(line_oe_o),
        .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o), .rx_len_o(rx_len_o),
        .rx_ferr_o(rx_ferr_o), .coll_o(coll_o), .busy_o(busy_o)
    );
    lbf_far #(.HC(int'(HC))) u_far (.mclk_i(mclk_i), .dut_oe_i(line_oe_o), .bus_o(bus));
    initial begin
        forever #2 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) cyc <= cyc + 1;
    task automatic tick();
        @(posedge mclk_i);
        #1;
    endtask : tick
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : cmp
    task automatic chk_win(input int v, input int lo, input int hi);
        n_compared++;
        if (v < lo || v >= hi) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %0h expected %0h..%0h", $time, v, lo, hi);
        end
    endtask : chk_win
    task automatic req(input logic [23:0] d, input logic [1:0] l, input logic [2:0] p);
        tx_valid_i = 1'b1;
        tx_data_i = d;
        tx_len_i = l;
        tx_prio_i = p;
        while (tx_ready_o !== 1'b1) tick();
        tick();
        t_take = cyc;
        tx_valid_i = 1'b0;
    endtask : req
    task automatic wait_oe();
        int i;
        for (i = 0; i < 800 && line_oe_o !== 1'b1; i++) tick();
        cmp(32'(i < 800), 32'h1);
        t_rise = cyc;
    endtask : wait_oe
    task automatic wait_idle();
        for (int i = 0; i < 400 && busy_o !== 1'b0; i++) tick();
    endtask : wait_idle
    // Samples the middle of both halves so edge jitter of a cycle cannot matter.
    task automatic get_frame(input int nb, input logic [23:0] d);
        logic [24:0] v;
        logic        a;
        int          bad_pair;
        v = 25'h0000000;
        bad_pair = 0;
        for (int i = 0; i <= nb; i++) begin
            repeat (HC / 2) tick();
            a = line_oe_o;
            repeat (HC) tick();
            bad_pair += int'(a === line_oe_o);
            v = {v[23:0], a};
            repeat (HC / 2) tick();
        end
        t_end = cyc;
        cmp(32'(v), 32'((25'h0000001 << nb) | 25'(d)));
        cmp(32'(bad_pair), 32'h0);
    endtask : get_frame
    task automatic t_frames();
        logic [23:0] d [5] = '{24'h0000A5, 24'h008001, 24'hC35A0F, 24'h007FFE, 24'h00003C};
        logic [1:0]  l [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
        logic [2:0]  p [5] = '{3'h5, 3'h4, 3'h3, 3'h2, 3'h1};
        int          s [5] = '{32'h118, 32'h104, 32'hF0, 32'hDC, 32'hDC};
        int          nb [5] = '{32'h8, 32'h10, 32'h18, 32'h18, 32'h8};
        cmp(32'({tx_ready_o, line_oe_o, busy_o, coll_o}), 32'h8);
        for (int k = 0; k < 5; k++) begin
            req(d[k], l[k], p[k]);
            wait_oe();
            chk_win(t_rise - t_take, s[k], s[k] + TL);
            get_frame(nb[k], d[k]);
            wait_idle();
            chk_win(cyc - t_end, ST, ST + TL);
        end
        $display("test frames done");
    endtask : t_frames
    task automatic t_twice();
        tx_twice_i = 1'b1;
        req(24'h000123, 2'h1, 3'h5);
        tx_twice_i = 1'b0;
        wait_oe();
        get_frame(16, 24'h000123);
        wait_oe();
        chk_win(t_rise - t_end, ST + SH, ST + SH + TL);
        get_frame(16, 24'h000123);
        wait_idle();
        $display("test twice done");
    endtask : t_twice
    task automatic t_rx();
        logic [24:0] v [4] = '{25'h0000196, 25'h1E10F33, 25'h0015AC3, 25'h001BEEF};
        int          n [4] = '{32'h9, 32'h19, 32'h11, 32'h11};
        logic [27:0] e [4] = '{28'h8000096, 28'hAE10F33, 28'h9005AC3, 28'h5005AC3};
        logic [1:0]  got;
        req(24'h000042, 2'h0, 3'h4);
        wait_oe();
        get_frame(8, 24'h000042);
        repeat (HC * 14) tick();
        for (int k = 0; k < 4; k++) begin
            got = 2'h0;
            fork
                u_far.send(v[k], n[k], k == 3);
                for (int i = 0; i < 3000 && got == 2'h0; i++) begin
                    tick();
                    got = {rx_valid_o, rx_ferr_o};
                end
            join
            cmp(32'({got, rx_len_o, rx_data_o}), 32'(e[k]));
        end
        $display("test receive done");
    endtask : t_rx
    task automatic t_coll();
        int hold [2] = '{32'h41, 32'hFA};
        for (int k = 0; k < 2; k++) begin
            wait_idle();
            req(24'h00005A, 2'h0, 3'h3);
            wait_oe();
            fork
                u_far.pull(hold[k]);
                begin
                    for (int i = 0; i < 200 && coll_o !== 1'b1; i++) tick();
                    cmp(32'(coll_o), 32'h1);
                    tick();
                    for (int i = 0; i < 100 && line_oe_o === 1'b1; i++) tick();
                    t_end = cyc;
                end
            join
            t_end = (k == 1) ? cyc : t_end;
            wait_oe();
            chk_win(t_rise - t_end, k ? SI : RC, (k ? SI : RC) + TL);
            get_frame(8, 24'h00005A);
        end
        $display("test collision done");
    endtask : t_coll
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    initial begin
        repeat (4) tick();
        rstn_i = 1'b1;
        tick();
        t_frames();
        t_twice();
        t_rx();
        t_coll();
        conclude();
    end
    initial begin
        repeat (60000) @(posedge mclk_i);
        bad_count++;
        conclude();
    end
endmodule : lbf_link_test
`default_nettype wire
